/* rtl/ptr_regs.sv */
// Power stage tuning register bank with its derived settings
`timescale 1ns/1ps
`include "ptr_params.svh"
module ptr_regs
	import ptr_pkg::*;
(
	input  wire logic               clk,
	input  wire logic               srst,
	// Management command port, code equals register offset
	input  wire logic               cmdValid,
	input  wire logic               cmdWrite,
	input  wire logic        [7:0]  cmdCode,
	input  wire logic        [31:0] cmdData,
	output logic             [31:0] rdData,
	output logic                    rdValid,
	output logic                    cmdError,
	// Transient response settings
	output logic             [5:0]  loadInnerThr,
	output logic             [5:0]  loadOuterThr,
	output logic             [5:0]  unloadInnerThr,
	output logic             [5:0]  unloadOuterThr,
	output logic             [3:0]  loadOuterWindow,
	output logic             [3:0]  loadInnerWindow,
	output logic             [3:0]  unloadOuterWindow,
	output logic             [3:0]  unloadInnerWindow,
	output logic             [7:0]  loadBlankLen,
	output logic             [7:0]  unloadBlankLen,
	// Output voltage fault detection
	input  wire logic               faultSample,
	input  wire logic               ovViolation,
	input  wire logic               uvViolation,
	input  wire logic               faultClear,
	output logic                    ovFault,
	output logic                    uvFault,
	output logic                    lowSideOn,
	// Temperatures, signed with four fraction bits
	input  wire logic signed [15:0] remoteTempInput,
	input  wire logic signed [15:0] internalTemp,
	output logic signed      [15:0] remoteTempReading,
	output logic signed      [31:0] senseCorrPpm,
	// Non-overlap control
	input  wire logic               freezeHiLo,
	input  wire logic               freezeLoHi,
	input  wire logic        [6:0]  minHiLo,
	input  wire logic        [6:0]  minLoHi,
	input  wire logic signed [7:0]  maxHiLo,
	input  wire logic signed [7:0]  maxLoHi,
	input  wire logic signed [7:0]  adaptHiLo,
	input  wire logic signed [7:0]  adaptLoHi,
	output logic signed      [7:0]  hiLoDelay,
	output logic signed      [7:0]  loHiDelay
);

	typedef struct packed {
		ptr_boost_s        boost;
		ptr_fault_s        fault;
		logic [15:0]       tempDiv;
		logic [15:0]       tempBias;
		ptr_tcomp_s        tcomp;
		ptr_dt_s           dt;
		logic [31:0]       rd;
		logic              rdv;
		logic              err;
		logic [5:0]        lIn;
		logic [5:0]        lOut;
		logic [5:0]        uIn;
		logic [5:0]        uOut;
		logic [7:0]        lBlank;
		logic [7:0]        uBlank;
		logic [4:0]        ovCnt;
		logic [4:0]        uvCnt;
		logic              ovF;
		logic              uvF;
		logic              lowOn;
		logic              frzHlQ;
		logic              frzLhQ;
		logic signed [7:0] hl;
		logic signed [7:0] lh;
		logic signed [15:0] remT;
		logic signed [31:0] corr;
	} ptr_regs_s;

	ptr_regs_s         st;
	ptr_regs_s         next_st;
	logic signed [15:0] calResult;

	////////////////////////////////////////////////////////////////////
	// Helpers

	// Bound a value to [lo, hi]; nine bits so a 2 ns minimum of 254 fits
	function automatic logic signed [7:0] clampDt(
		input logic signed [8:0] v,
		input logic signed [8:0] lo,
		input logic signed [8:0] hi
	);
		logic signed [8:0] r;
		r = v;
		if (r < lo)
			r = lo;
		if (r > hi)
			r = hi;
		return 8'(r);
	endfunction

	// Store limit: the documented -15..60 ns window
	function automatic logic signed [7:0] limitDt(
		input logic signed [7:0] v
	);
		return clampDt(9'(v), `PTR_DT_MIN_NS, `PTR_DT_MAX_NS);
	endfunction

	// Code to blanking length in tsw/64 units
	function automatic logic [7:0] blankLen(input logic [3:0] code);
		logic [127:0] tbl;
		tbl = `PTR_BLANK_TABLE;
		return tbl[code*8 +: 8];
	endfunction

	// Consecutive-violation counter; saturates at 31, above any need
	function automatic logic [4:0] violStep(
		input logic [4:0] cnt,
		input logic       viol
	);
		if (!viol)
			return 5'h00;
		if (cnt == 5'h1f)
			return cnt;
		return cnt + 5'h01;
	endfunction

	////////////////////////////////////////////////////////////////////
	// Remote temperature calibration

	ptr_temp_cal #(
		.TEMP_W (16)
	) u_cal (
		.clk     (clk),
		.srst    (srst),
		.extTemp (remoteTempInput),
		.divisor (st.tempDiv),
		.bias    (st.tempBias),
		.result  (calResult)
	);

	////////////////////////////////////////////////////////////////////
	// Next state

	always_comb begin
		logic [4:0]         need;
		logic signed [31:0] tDeg;
		logic signed [8:0]  lo;
		next_st = st;
		need = {1'b0, st.fault.violCount} + 5'h01;
		tDeg = '0;
		lo = '0;
		next_st.rdv = 1'b0;
		next_st.err = 1'b0;

		// Command decode: writes store, reads answer next cycle
		if (cmdValid) begin
			next_st.rdv = !cmdWrite;
			next_st.rd = '0;
			unique case (cmdCode)
				`PTR_OFS_BOOST: begin
					if (cmdWrite)
						next_st.boost = cmdData;
					next_st.rd = st.boost;
				end
				`PTR_OFS_FAULT: begin
					if (cmdWrite)
						next_st.fault = cmdData[7:0];
					next_st.rd = 32'(st.fault);
				end
				`PTR_OFS_DIV: begin
					if (cmdWrite)
						next_st.tempDiv = cmdData[15:0];
					next_st.rd = 32'(st.tempDiv);
				end
				`PTR_OFS_BIAS: begin
					if (cmdWrite)
						next_st.tempBias = cmdData[15:0];
					next_st.rd = 32'(st.tempBias);
				end
				`PTR_OFS_TCOMP: begin
					if (cmdWrite)
						next_st.tcomp = cmdData[7:0];
					next_st.rd = 32'(st.tcomp);
				end
				`PTR_OFS_DT: begin
					// Out-of-window values are pulled to the limit
					if (cmdWrite) begin
						next_st.dt.hiToLo = limitDt(cmdData[15:8]);
						next_st.dt.loToHi = limitDt(cmdData[7:0]);
					end
					next_st.rd = 32'(st.dt);
				end
				default: begin
					next_st.err = 1'b1;
					next_st.rdv = 1'b0;
				end
			endcase
		end

		// Comparator thresholds in 0.5 % steps of the output voltage
		next_st.lIn = 6'({3'h0, st.boost.loadInner} + 6'h01);
		next_st.uIn = 6'({3'h0, st.boost.unloadInner} + 6'h01);
		next_st.lOut = 6'(next_st.lIn * st.boost.outerMult);
		next_st.uOut = 6'(next_st.uIn * st.boost.outerMult);
		next_st.lBlank = blankLen(st.boost.loadBlank);
		next_st.uBlank = blankLen(st.boost.unloadBlank);

		// Fault filter; bits 6:4 are never looked at
		if (faultSample) begin
			next_st.ovCnt = violStep(st.ovCnt, ovViolation);
			next_st.uvCnt = violStep(st.uvCnt, uvViolation);
		end
		// Clear first so a fault arriving in the same cycle survives
		if (faultClear) begin
			next_st.ovF = 1'b0;
			next_st.uvF = 1'b0;
		end
		// Declared on a sample only: a level test would undo every
		// clear while the count still stands at the threshold
		if (faultSample && next_st.ovCnt >= need)
			next_st.ovF = 1'b1;
		if (faultSample && next_st.uvCnt >= need)
			next_st.uvF = 1'b1;
		// Low side only when the option is set, else it stays off
		next_st.lowOn = next_st.ovF & st.fault.lowSideOnOv;

		// Calibrated remote reading, refreshed after each divide
		next_st.remT = calResult;

		// Sense correction in ppm; negative to cancel a rising tempco
		tDeg = (st.tcomp.srcRemote ? 32'(st.remT) : 32'(internalTemp))
			>>> `PTR_FRAC_BITS;
		next_st.corr = -(32'(st.tcomp.factor) * `PTR_TC_STEP
			* (tDeg - `PTR_TREF_C));

		// Each interval: adaptive or frozen, bit 15 of mode
		next_st.frzHlQ = freezeHiLo;
		next_st.frzLhQ = freezeLoHi;
		lo = 9'({minHiLo, 1'b0});
		if (!freezeHiLo)
			next_st.hl = clampDt(9'(adaptHiLo), lo, 9'(maxHiLo));
		else
			next_st.hl = clampDt(9'(st.dt.hiToLo), lo,
				9'(maxHiLo));
		lo = 9'({minLoHi, 1'b0});
		if (!freezeLoHi)
			next_st.lh = clampDt(9'(adaptLoHi), lo, 9'(maxLoHi));
		else
			next_st.lh = clampDt(9'(st.dt.loToHi), lo,
				9'(maxLoHi));

		// Entering frozen mode keeps the interval last in use; it
		// overrides a host write landing in the same cycle
		if (freezeHiLo && !st.frzHlQ) begin
			next_st.dt.hiToLo = st.hl;
			next_st.hl = st.hl;
		end
		if (freezeLoHi && !st.frzLhQ) begin
			next_st.dt.loToHi = st.lh;
			next_st.lh = st.lh;
		end
	end

	////////////////////////////////////////////////////////////////////
	// State register

	always_ff @(posedge clk) begin
		if (srst) begin
			st <= '0;
			st.boost <= `PTR_RST_BOOST;
			st.fault <= `PTR_RST_FAULT;
			st.tempDiv <= `PTR_RST_DIV;
			st.tempBias <= `PTR_RST_BIAS;
			st.tcomp <= `PTR_RST_TCOMP;
			st.dt <= `PTR_RST_DT;
			st.frzHlQ <= 1'b1;
			st.frzLhQ <= 1'b1;
		end else begin
			st <= next_st;
		end
	end

	////////////////////////////////////////////////////////////////////
	// Outputs, each straight from the state register

	assign rdData            = st.rd;
	assign rdValid           = st.rdv;
	assign cmdError          = st.err;
	assign loadInnerThr      = st.lIn;
	assign loadOuterThr      = st.lOut;
	assign unloadInnerThr    = st.uIn;
	assign unloadOuterThr    = st.uOut;
	assign loadOuterWindow   = st.boost.loadOuterTime;
	assign loadInnerWindow   = st.boost.loadInnerTime;
	assign unloadOuterWindow = st.boost.unloadOuterTime;
	assign unloadInnerWindow = st.boost.unloadInnerTime;
	assign loadBlankLen      = st.lBlank;
	assign unloadBlankLen    = st.uBlank;
	assign ovFault           = st.ovF;
	assign uvFault           = st.uvF;
	assign lowSideOn         = st.lowOn;
	assign remoteTempReading = st.remT;
	assign senseCorrPpm      = st.corr;
	assign hiLoDelay         = st.hl;
	assign loHiDelay         = st.lh;

endmodule

/* rtl/ptr_params.svh */
// Constants of the power stage tuning register bank
// Behaviour
// - 32-bit transient word, resets to zero
// - Bits 31:30 multiply inner into outer threshold
// - Load inner threshold is 0.5% times (code+1)
// - Unload inner threshold is 0.5% times (code+1)
// - Load correction times in tsw/64 units
// - Unload correction times in tsw/64 units
// - Bits 7:4 and 3:0 pick blanking times
// - Blanking codes map to fixed tsw/64 counts
// - Fault bit 7 turns low side on at OV
// - Fault declared after count plus one violations
// - Remote reading is temperature over divisor
// - Bias is added to the scaled reading
// - Bit 7 picks internal or remote sensor
// - Bits 6:0 give factor per 100 ppm
// - Correction is applied with negative sign
// - Upper byte high-low, lower byte low-high
// - Positive separates drives, negative overlaps them
// - Frozen intervals bounded by minimum and maximum
// - Leaving adaptive mode freezes last interval
// - Interval resets 1014h, limited -15 to 60
// - Mode bit 15 clear adaptive, set frozen
`ifndef PTR_PARAMS_SVH
`define PTR_PARAMS_SVH

// Command codes of the registers
`define PTR_OFS_BOOST  8'hd7
`define PTR_OFS_FAULT  8'hd8
`define PTR_OFS_DIV    8'hd9
`define PTR_OFS_BIAS   8'hda
`define PTR_OFS_TCOMP  8'hdc
`define PTR_OFS_DT     8'hdd

// Reset values
`define PTR_RST_BOOST  32'h0000_0000
`define PTR_RST_FAULT  8'h00
`define PTR_RST_DIV    16'hba00
`define PTR_RST_BIAS   16'h8000
`define PTR_RST_TCOMP  8'h28
`define PTR_RST_DT     16'h1014

// Non-overlap limits in ns
`define PTR_DT_MIN_NS  (-9'sh00f)
`define PTR_DT_MAX_NS  9'sh03c

// Thermal correction: reference degrees and ppm per code step
`define PTR_TREF_C     32'sh0000_0019
`define PTR_TC_STEP    32'sh0000_0064

// Temperatures are signed with this many fraction bits
`define PTR_FRAC_BITS  4
// Extra quotient bits kept through the divide
`define PTR_DIV_GUARD  8
// Blanking lengths in tsw/64 units, code 15 in the top byte
`define PTR_BLANK_TABLE {8'he1, 8'hc1, 8'hb1, 8'ha1, 8'h81, 8'h61, \
	8'h51, 8'h41, 8'h31, 8'h21, 8'h11, 8'h09, 8'h05, 8'h03, 8'h02, \
	8'h01}

`endif

/* rtl/ptr_pkg.sv */
// Field layouts of the power stage tuning registers
package ptr_pkg;

	typedef struct packed {
		logic [1:0] outerMult;
		logic [2:0] loadInner;
		logic [2:0] unloadInner;
		logic [3:0] loadOuterTime;
		logic [3:0] loadInnerTime;
		logic [3:0] unloadOuterTime;
		logic [3:0] unloadInnerTime;
		logic [3:0] loadBlank;
		logic [3:0] unloadBlank;
	} ptr_boost_s;

	typedef struct packed {
		logic       lowSideOnOv;
		logic [2:0] unused;
		logic [3:0] violCount;
	} ptr_fault_s;

	typedef struct packed {
		logic       srcRemote;
		logic [6:0] factor;
	} ptr_tcomp_s;

	typedef struct packed {
		logic signed [7:0] hiToLo;
		logic signed [7:0] loToHi;
	} ptr_dt_s;

endpackage

/* rtl/ptr_temp_cal.sv */
// Remote temperature calibration: reading / divisor + bias, linear-11
`timescale 1ns/1ps
`include "ptr_params.svh"
module ptr_temp_cal
	import ptr_pkg::*;
#(
	parameter int TEMP_W = 16
) (
	input  wire logic                     clk,
	input  wire logic                     srst,
	input  wire logic signed [TEMP_W-1:0] extTemp,
	input  wire logic        [15:0]       divisor,
	input  wire logic        [15:0]       bias,
	output logic signed      [TEMP_W-1:0] result
);
	localparam int NUM_W = TEMP_W + `PTR_DIV_GUARD;

	// The bit counter and the 32-bit unscaling only serve this range
	if (TEMP_W < 8 || TEMP_W > 24) begin : g_bad_width
		$error("ptr_temp_cal: TEMP_W out of range");
	end

	typedef struct packed {
		logic                     busy;
		logic [5:0]               cnt;
		logic [NUM_W-1:0]         num;
		logic [11:0]              rem;
		logic [10:0]              den;
		logic                     neg;
		logic signed [4:0]        ex;
		logic signed [TEMP_W-1:0] res;
	} ptr_cal_s;

	ptr_cal_s st;
	ptr_cal_s next_st;

	// Long division one bit a cycle; trades speed for area, the
	// temperature changes far slower than the 24-odd cycles it takes
	always_comb begin
		logic signed [10:0] mant;
		logic signed [31:0] q;
		logic signed [31:0] ofs;
		logic signed [4:0]  oe;
		logic [11:0]        trial;
		next_st = st;
		mant = divisor[10:0];
		q = '0;
		ofs = '0;
		oe = bias[15:11];
		trial = '0;
		if (!st.busy) begin
			// Zero divisor keeps the last result instead of blowing up
			if (mant != 11'sh000) begin
				next_st.busy = 1'b1;
				next_st.cnt = 6'(NUM_W);
				next_st.num = NUM_W'(extTemp[TEMP_W-1] ?
					-extTemp : extTemp) << `PTR_DIV_GUARD;
				next_st.den = mant[10] ? 11'(-mant) : 11'(mant);
				next_st.neg = extTemp[TEMP_W-1] ^ mant[10];
				next_st.ex = divisor[15:11];
				next_st.rem = '0;
			end
		end else if (st.cnt != 6'h00) begin
			trial = {st.rem[10:0], st.num[NUM_W-1]};
			next_st.num = {st.num[NUM_W-2:0], 1'b0};
			if (trial >= {1'b0, st.den}) begin
				next_st.rem = trial - {1'b0, st.den};
				next_st.num[0] = 1'b1;
			end else begin
				next_st.rem = trial;
			end
			next_st.cnt = st.cnt - 6'h01;
		end else begin
			// Undo the divisor exponent, then drop the guard bits
			q = 32'(st.num);
			q = st.neg ? -q : q;
			q = (st.ex >= 0) ? q >>> st.ex : q <<< (-st.ex);
			q = q >>> `PTR_DIV_GUARD;
			// Bias converted to the same fixed point
			ofs = 32'(signed'(bias[10:0]));
			ofs = (oe >= -`PTR_FRAC_BITS) ? ofs <<< (oe + `PTR_FRAC_BITS)
				: ofs >>> (-oe - `PTR_FRAC_BITS);
			next_st.res = TEMP_W'(q + ofs);
			next_st.busy = 1'b0;
		end
	end

	// State register
	always_ff @(posedge clk) begin
		if (srst)
			st <= '0;
		else
			st <= next_st;
	end

	assign result = st.res;

endmodule

/* testbench/ptr_stage_model.sv */
// Behavioural model of the power stage facing the tuning bank
`timescale 1ns/1ps
module ptr_stage_model
	import ptr_pkg::*;
(
	input  wire logic        clk,
	input  wire logic        srst,
	input  wire logic        ovHold,
	input  wire logic        uvHold,
	input  wire logic        step,
	output logic             faultSample,
	output logic             ovViolation,
	output logic             uvViolation,
	output logic signed [7:0] adaptHiLo,
	output logic signed [7:0] adaptLoHi
);
	logic [1:0] phase;

	// Comparators are sampled every fourth cycle
	always_ff @(posedge clk) begin
		phase <= srst ? 2'h0 : phase + 2'h1;
		faultSample <= !srst && phase == 2'h3;
	end

	// Off the sample the levels flip, so a stale match cannot hide
	assign ovViolation = faultSample ? ovHold : !ovHold;
	assign uvViolation = faultSample ? uvHold : !uvHold;

	// Adaptive intervals wander over the whole signed range on request
	always_ff @(posedge clk) begin
		if (srst) begin
			adaptHiLo <= 8'sh20;
			adaptLoHi <= 8'sh08;
		end else if (step) begin
			adaptHiLo <= adaptHiLo * 8'sd37 + 8'sd23;
			adaptLoHi <= adaptLoHi * 8'sd29 - 8'sd41;
		end
	end
endmodule

/* testbench/ptr_regs_assertions.sv */
// Port-level assertions of the tuning register bank
`timescale 1ns/1ps
module ptr_regs_assertions
	import ptr_pkg::*;
(
	input wire logic               clk,
	input wire logic               srst,
	input wire logic               cmdValid,
	input wire logic               cmdWrite,
	input wire logic        [7:0]  cmdCode,
	input wire logic        [31:0] cmdData,
	input wire logic        [31:0] rdData,
	input wire logic               rdValid,
	input wire logic               cmdError,
	input wire logic        [5:0]  loadInnerThr,
	input wire logic        [5:0]  unloadOuterThr,
	input wire logic        [3:0]  loadOuterWindow,
	input wire logic               faultSample,
	input wire logic               ovViolation,
	input wire logic               faultClear,
	input wire logic               ovFault,
	input wire logic               lowSideOn,
	input wire logic signed [7:0]  hiLoDelay,
	input wire logic signed [7:0]  loHiDelay
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (srst);
	logic mapped;
	logic wrBoost;

	// Decoded command classes
	assign mapped = cmdCode inside {8'hd7, 8'hd8, 8'hd9, 8'hda, 8'hdc, 8'hdd};
	assign wrBoost = cmdValid && cmdWrite && cmdCode == 8'hd7;

	a_read_answer: assert property (
		cmdValid && !cmdWrite && mapped |=> rdValid && !cmdError)
		else $error("Mapped read got no answer");
	a_unmapped_refused: assert property (
		cmdValid && !mapped |=> cmdError && !rdValid && rdData == 32'h0)
		else $error("Unmapped command not refused");
	a_inner_step: assert property (
		wrBoost |-> ##2
		loadInnerThr == {3'h0, $past(cmdData[29:27], 2)} + 6'h1)
		else $error("Load inner threshold wrong");
	a_outer_mult: assert property (
		wrBoost |-> ##2 unloadOuterThr == $past(cmdData[31:30], 2) *
		({3'h0, $past(cmdData[26:24], 2)} + 6'h1))
		else $error("Unload outer threshold wrong");
	a_window_field: assert property (
		wrBoost |=> loadOuterWindow == $past(cmdData[23:20]))
		else $error("Load outer window wrong");
	a_fault_sticky: assert property (
		ovFault && !faultClear |=> ovFault)
		else $error("Fault flag dropped without clear");
	a_fault_cause: assert property (
		$rose(ovFault) |-> $past(faultSample && ovViolation))
		else $error("Fault raised without violating sample");
	a_low_side: assert property (
		lowSideOn |-> ovFault)
		else $error("Low side on without fault");
	a_interval_range: assert property (
		hiLoDelay >= -8'sd15 && hiLoDelay <= 8'sd60 &&
		loHiDelay >= -8'sd15 && loHiDelay <= 8'sd60)
		else $error("Interval out of range");
endmodule

bind ptr_regs ptr_regs_assertions chk (
	.clk(clk), .srst(srst), .cmdValid(cmdValid), .cmdWrite(cmdWrite),
	.cmdCode(cmdCode), .cmdData(cmdData), .rdData(rdData),
	.rdValid(rdValid), .cmdError(cmdError), .loadInnerThr(loadInnerThr),
	.unloadOuterThr(unloadOuterThr), .loadOuterWindow(loadOuterWindow),
	.faultSample(faultSample), .ovViolation(ovViolation),
	.faultClear(faultClear), .ovFault(ovFault), .lowSideOn(lowSideOn),
	.hiLoDelay(hiLoDelay), .loHiDelay(loHiDelay)
);

/* testbench/test_ptr_regs.sv */
// Self-checking bench of the tuning register bank
`timescale 1ns/1ps
module test_ptr_regs
	import ptr_pkg::*;
();
	logic               clk, srst, cmdValid, cmdWrite, faultSample;
	logic               ovViolation, uvViolation, faultClear, ovFault;
	logic               uvFault, lowSideOn, rdValid, cmdError;
	logic               freezeHiLo, freezeLoHi, ovHold, uvHold, step;
	logic        [7:0]  cmdCode, loadBlankLen, unloadBlankLen;
	logic        [31:0] cmdData, rdData, rd, d;
	logic        [5:0]  loadInnerThr, loadOuterThr;
	logic        [5:0]  unloadInnerThr, unloadOuterThr;
	logic        [3:0]  loadOuterWindow, loadInnerWindow;
	logic        [3:0]  unloadOuterWindow, unloadInnerWindow;
	logic signed [15:0] remoteTempInput, internalTemp, remoteTempReading;
	logic signed [31:0] senseCorrPpm;
	logic        [6:0]  minHiLo, minLoHi;
	logic signed [7:0]  maxHiLo, maxLoHi, adaptHiLo, adaptLoHi;
	logic signed [7:0]  hiLoDelay, loHiDelay;
	logic        [15:0] lastExp;
	int                 n_mismatch, check_count, k;
	logic [7:0]  codes [8] = '{8'hd7, 8'hd8, 8'hd9, 8'hda, 8'hdc, 8'hdd,
		8'hdb, 8'hde};
	logic [31:0] rstv [8] = '{32'h0, 32'h0, 32'hba00, 32'h8000, 32'h28,
		32'h1014, 32'h0, 32'h0};
	logic [7:0]  blankLen [16] = '{8'h01, 8'h02, 8'h03, 8'h05, 8'h09,
		8'h11, 8'h21, 8'h31, 8'h41, 8'h51, 8'h61, 8'h81, 8'ha1, 8'hb1,
		8'hc1, 8'he1};

	ptr_regs dut (.clk(clk), .srst(srst), .cmdValid(cmdValid),
		.cmdWrite(cmdWrite), .cmdCode(cmdCode), .cmdData(cmdData),
		.rdData(rdData), .rdValid(rdValid), .cmdError(cmdError),
		.loadInnerThr(loadInnerThr), .loadOuterThr(loadOuterThr),
		.unloadInnerThr(unloadInnerThr), .unloadOuterThr(unloadOuterThr),
		.loadOuterWindow(loadOuterWindow), .loadInnerWindow(loadInnerWindow),
		.unloadOuterWindow(unloadOuterWindow),
		.unloadInnerWindow(unloadInnerWindow), .loadBlankLen(loadBlankLen),
		.unloadBlankLen(unloadBlankLen), .faultSample(faultSample),
		.ovViolation(ovViolation), .uvViolation(uvViolation),
		.faultClear(faultClear), .ovFault(ovFault), .uvFault(uvFault),
		.lowSideOn(lowSideOn), .remoteTempInput(remoteTempInput),
		.internalTemp(internalTemp), .remoteTempReading(remoteTempReading),
		.senseCorrPpm(senseCorrPpm), .freezeHiLo(freezeHiLo),
		.freezeLoHi(freezeLoHi), .minHiLo(minHiLo), .minLoHi(minLoHi),
		.maxHiLo(maxHiLo), .maxLoHi(maxLoHi), .adaptHiLo(adaptHiLo),
		.adaptLoHi(adaptLoHi), .hiLoDelay(hiLoDelay), .loHiDelay(loHiDelay));
	ptr_stage_model stage (.clk(clk), .srst(srst), .ovHold(ovHold),
		.uvHold(uvHold), .step(step), .faultSample(faultSample),
		.ovViolation(ovViolation), .uvViolation(uvViolation),
		.adaptHiLo(adaptHiLo), .adaptLoHi(adaptLoHi));

	function automatic logic [7:0] clp(input int v, input int lo, input int hi);
		return 8'(v < lo ? lo : (v > hi ? hi : v));
	endfunction
	// Expected readback; interval bytes are clamped on store
	function automatic logic [31:0] expRd(input logic [7:0] c,
		input logic [31:0] v);
		case (c)
			8'hd7: return v;
			8'hd8, 8'hdc: return {24'h0, v[7:0]};
			8'hd9, 8'hda: return {16'h0, v[15:0]};
			8'hdd: return {16'h0, clp($signed(v[15:8]), -15, 60),
				clp($signed(v[7:0]), -15, 60)};
			default: return 32'h0;
		endcase
	endfunction
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		check_count++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	// One command; answer flags are looked at in the cycle they stand
	task automatic cmd(input logic wr, input logic [7:0] c,
		input logic [31:0] v);
		logic m;
		m = expRd(c, 32'hffff) != 32'h0;
		cmdValid = 1'b1;
		cmdWrite = wr;
		cmdCode = c;
		cmdData = v;
		@(negedge clk);
		check({rdValid, cmdError}, {!wr && m, !m});
		rd = rdData;
		cmdValid = 1'b0;
		@(negedge clk);
	endtask
	task automatic checkBoost(input logic [31:0] v);
		logic [5:0] li;
		logic [5:0] ui;
		li = 6'(v[29:27]) + 6'h1;
		ui = 6'(v[26:24]) + 6'h1;
		check({loadInnerThr, unloadInnerThr}, {li, ui});
		check({loadOuterThr, unloadOuterThr},
			{6'(li * v[31:30]), 6'(ui * v[31:30])});
		check({loadOuterWindow, loadInnerWindow,
			unloadOuterWindow, unloadInnerWindow}, v[23:8]);
		check({loadBlankLen, unloadBlankLen},
			{blankLen[v[7:4]], blankLen[v[3:0]]});
	endtask
	task automatic samples(input int n);
		repeat (n) @(posedge clk iff faultSample);
		@(negedge clk);
	endtask
	task automatic endTest(input string s);
		$display("test %s done", s);
	endtask
	task automatic complete_run();
		$display("checks %0d mismatches %0d", check_count, n_mismatch);
		if (n_mismatch == 0 && check_count > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask

	// Free running 100 MHz clock
	initial begin
		clk = 1'b0;
		forever #5 clk = !clk;
	end
	// Whole run is about 500 cycles; this margin cuts a hang short
	initial begin
		#300000;
		n_mismatch++;
		complete_run();
	end

	initial begin
		{srst, freezeHiLo, freezeLoHi} = 3'b111;
		{cmdValid, cmdWrite, faultClear, ovHold, uvHold, step} = 6'h0;
		cmdCode = 8'h00;
		cmdData = 32'h0;
		remoteTempInput = 16'sd400;
		internalTemp = 16'sd720;
		{minHiLo, minLoHi, maxHiLo, maxLoHi} = {7'd3, 7'd2, 8'sd50, 8'sd40};
		void'($urandom(32'h3004a827));
		repeat (12) @(negedge clk);
		srst = 1'b0;
		for (int i = 0; i < 8; i++) begin
			cmd(1'b0, codes[i], 32'h0);
			check(rd, rstv[i]);
		end
		endTest("reset");
		// Random traffic with the blank codes and limit corners mixed in
		for (int n = 0; n < 64; n++) begin
			k = n < 16 ? 0 : n % 8;
			d = $urandom();
			if (n < 16)
				d[7:0] = {4'(n), 4'(15 - n)};
			if (n == 16)
				d = 32'hffffffff;
			if (n == 21)
				d = 32'h7f80;
			if (n == 29)
				d = 32'hf13c;
			if (k == 1)
				d[6:4] = 3'h0;
			cmd(1'b1, codes[k], d);
			if (k == 0)
				checkBoost(d);
			cmd(1'b0, codes[k], 32'h0);
			check(rd, expRd(codes[k], d));
			if (k == 5)
				check({hiLoDelay, loHiDelay},
					{clp($signed(rd[15:8]), 6, 50),
					clp($signed(rd[7:0]), 4, 40)});
		end
		endTest("registers");
		// Two violations, a clean sample, then three in a row
		cmd(1'b1, 8'hd8, 32'h82);
		ovHold = 1'b1;
		samples(2);
		ovHold = 1'b0;
		samples(1);
		ovHold = 1'b1;
		samples(2);
		check(ovFault, 1'b0);
		samples(1);
		check({ovFault, lowSideOn, uvFault}, 3'b110);
		ovHold = 1'b0;
		faultClear = 1'b1;
		@(negedge clk);
		faultClear = 1'b0;
		check(ovFault, 1'b0);
		cmd(1'b1, 8'hd8, 32'h00);
		uvHold = 1'b1;
		samples(1);
		uvHold = 1'b0;
		ovHold = 1'b1;
		samples(1);
		check({ovFault, lowSideOn, uvFault}, 3'b101);
		ovHold = 1'b0;
		endTest("faults");
		// Reading is 25 degC over divisor plus 2 degC of bias
		cmd(1'b1, 8'hd9, 32'hba00);
		cmd(1'b1, 8'hda, 32'h0002);
		repeat (60) @(negedge clk);
		check(remoteTempReading, 32'h01b0);
		cmd(1'b1, 8'hd9, 32'h0002);
		repeat (60) @(negedge clk);
		check(remoteTempReading, 32'h00e8);
		cmd(1'b1, 8'hdc, 32'h8a);
		repeat (3) @(negedge clk);
		check(senseCorrPpm, 32'(11000));
		cmd(1'b1, 8'hdc, 32'h28);
		repeat (3) @(negedge clk);
		check(senseCorrPpm, 32'(-80000));
		endTest("temperature");
		// Adaptive intervals follow the stage, then freeze on the last one
		{freezeHiLo, freezeLoHi} = 2'b00;
		for (int i = 0; i < 8; i++) begin
			step = 1'b1;
			@(negedge clk);
			step = 1'b0;
			repeat (2) @(negedge clk);
			lastExp = {clp(adaptHiLo, 6, 50), clp(adaptLoHi, 4, 40)};
			check({hiLoDelay, loHiDelay}, lastExp);
		end
		{freezeHiLo, freezeLoHi} = 2'b11;
		@(negedge clk);
		step = 1'b1;
		@(negedge clk);
		step = 1'b0;
		repeat (4) @(negedge clk);
		check({hiLoDelay, loHiDelay}, lastExp);
		cmd(1'b0, 8'hdd, 32'h0);
		check(rd, {16'h0, lastExp});
		endTest("intervals");
		complete_run();
	end
endmodule
